// [fcs_array.sv]
`timescale 1ns/100ps
`default_nettype none
module fcs_array #(
    parameter int DEPTH = fcs_pkg::ARRAY_DEPTH,
    parameter int AW    = fcs_pkg::ARRAY_AW
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      we,
    input  wire logic [AW-1:0]             waddr,
    input  wire logic [7:0]                wdata,
    input  wire logic                      erase_sect,
    input  wire logic                      erase_all,
    input  wire logic [fcs_pkg::SECT_W-1:0] sect,
    input  wire logic [AW-1:0]             raddr,
    output logic [7:0]                     rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } fcs_arr_t;

    fcs_arr_t s_reg;
    fcs_arr_t s_next;

    // Erase forces whole 4 KB sectors to the erased value
    always_comb
    begin
        s_next = s_reg;
        for (int i = 0; i < DEPTH; i++)
        begin
            if (erase_all || (erase_sect && (AW'(i) >> (AW - fcs_pkg::SECT_W)) == AW'(sect)))
                s_next.mem[i] = fcs_pkg::ERASED_BYTE;
        end
        if (we)
            s_next.mem[waddr] = wdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_reg <= {DEPTH{fcs_pkg::ERASED_BYTE}};
        else
            s_reg <= s_next;
    end

    assign rdata = s_reg.mem[raddr];
endmodule
`default_nettype wire

// [fcs_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fcs_cpu_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [16:0]      paddr,
    output logic [31:0]      pwdata,
    output logic             err
);
    initial {psel, penable, pwrite, paddr, pwdata, err} = '0;
    // One transfer; held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [16:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A slave that never answers ends the run
        if (pready !== 1'b1)
            test_flash_command_sequencer.tmo();
    endtask
endmodule
`default_nettype wire

// [fcs_pkg.sv]
package fcs_pkg;
    // ------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------
    localparam logic [16:0] REG_CTRL_ONE   = 17'h00000;
    localparam logic [16:0] REG_COMMIT     = 17'h00004;
    localparam logic [16:0] REG_STATUS     = 17'h00008;
    localparam int          WIN_BIT        = 16;
    localparam logic [2:0]  FEN_RESET      = 3'h2;
    localparam logic [2:0]  FEN_ON         = 3'h5;
    localparam logic [1:0]  AREA_RESET     = 2'h0;
    localparam logic [7:0]  COMMIT_KEY     = 8'hD5;
    // ------------------------------------------------------------
    // Command sequence codes
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_LO_555    = 12'h555;
    localparam logic [11:0] ADDR_LO_AAA    = 12'hAAA;
    localparam logic [1:0]  ADDR_HI_OK     = 2'h3;
    localparam logic [7:0]  D_UNLOCK1      = 8'hAA;
    localparam logic [7:0]  D_UNLOCK2      = 8'h55;
    localparam logic [7:0]  D_PROG         = 8'hA0;
    localparam logic [7:0]  D_ERASE        = 8'h80;
    localparam logic [7:0]  D_ID_ENTRY     = 8'h90;
    localparam logic [7:0]  D_ID_EXIT      = 8'hF0;
    localparam logic [7:0]  D_SECURE       = 8'hA5;
    localparam logic [7:0]  D_SEC_DATA     = 8'h00;
    localparam logic [7:0]  D_CHIP         = 8'h10;
    localparam logic [7:0]  D_SECTOR       = 8'h30;
    localparam logic [15:0] A_SEC_STATUS   = 16'hFF7F;
    localparam logic [15:0] A_VENDOR_ID    = 16'hF000;
    localparam logic [15:0] A_FLASH_ID     = 16'hF001;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
    localparam logic [7:0]  SEC_ON_BYTE    = 8'h00;
    localparam int          TOGGLE_BIT     = 6;
    // ------------------------------------------------------------
    // Modes, timing
    // ------------------------------------------------------------
    localparam logic [1:0]  MODE_MCU       = 2'h0;
    localparam logic [1:0]  MODE_SER       = 2'h1;
    localparam logic [1:0]  MODE_PAR       = 2'h2;
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          PROG_TIME_US   = 40;
    localparam int          SECP_TIME_US   = 40;
    localparam int          ERASE_TIME_MS  = 30;
    localparam int          PROG_CYCLES    = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int          SECP_CYCLES    = SECP_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int          ERASE_CYCLES   = ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          TW             = 21;
    localparam int          ARRAY_DEPTH    = 16384;
    localparam int          ARRAY_AW       = 14;
    localparam int          SECT_W         = 2;
endpackage

// [fcs_sequencer.sv]
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fcs_sequencer #(
    parameter int          ERASE_CYCLES = fcs_pkg::ERASE_CYCLES,
    parameter logic [7:0]  VENDOR_ID    = 8'h11, // Arbitrary value
    parameter logic [7:0]  FLASH_ID     = 8'h22  // Arbitrary value
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [16:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  prom_mode,
    output logic             flash_busy,
    output logic             loader_lock
);
    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_UNL1 = 9'h002,
        ST_UNL2 = 9'h004,
        ST_PROG = 9'h008,
        ST_ER3  = 9'h010,
        ST_ER4  = 9'h020,
        ST_ER5  = 9'h040,
        ST_SECP = 9'h080,
        ST_HOLD = 9'h100
    } fcs_state_t;

    typedef enum logic [3:0] {
        OP_PROG = 4'h1,
        OP_SECT = 4'h2,
        OP_CHIP = 4'h4,
        OP_SECP = 4'h8
    } fcs_op_t;

    typedef struct packed {
        fcs_state_t  st;
        fcs_op_t     op;
        logic [2:0]  fen_pend;
        logic [1:0]  area_pend;
        logic [2:0]  fen_act;
        logic [1:0]  area_act;
        logic        id_mode;
        logic        secure;
        logic        toggle;
        logic        busy;
        logic [15:0] tgt_addr;
        logic [7:0]  tgt_data;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        lock;
        logic [fcs_pkg::TW-1:0] busy_cnt;
    } fcs_seq_t;

    localparam fcs_seq_t RESET_S = '{
        st: ST_IDLE, op: OP_PROG, fen_pend: fcs_pkg::FEN_RESET,
        area_pend: fcs_pkg::AREA_RESET, fen_act: fcs_pkg::FEN_RESET,
        area_act: fcs_pkg::AREA_RESET, default: '0};

    fcs_seq_t s_reg;
    fcs_seq_t s_next;

    logic                        tmr_start;
    logic [fcs_pkg::TW-1:0]      tmr_cycles;
    logic                        tmr_done;
    logic [7:0]                  arr_rdata;
    logic                        arr_we;
    logic                        arr_esect;
    logic                        arr_eall;

    // Unlock and command addresses: nibble C..F, low twelve bits compared
    function automatic logic cmd_addr(input logic [15:0] a, input logic [11:0] lo);
        return (a[15:14] == fcs_pkg::ADDR_HI_OK) && (a[11:0] == lo);
    endfunction

    // Program and erase targets must sit in the C000..FFFF window
    function automatic logic in_window(input logic [15:0] a);
        return a[15:14] == fcs_pkg::ADDR_HI_OK;
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic        acc;
    logic        fw;
    logic        fr;
    logic [15:0] fa;
    logic [7:0]  fd;
    logic        en;
    logic        par_lock;
    logic        is555;
    logic        isaaa;
    logic        start_unl;

    assign acc       = psel && penable && !s_reg.pready;
    assign fw        = acc && pwrite && paddr[fcs_pkg::WIN_BIT];
    assign fr        = acc && !pwrite && paddr[fcs_pkg::WIN_BIT];
    assign fa        = paddr[15:0];
    assign fd        = pwdata[7:0];
    assign en        = (s_reg.fen_act == fcs_pkg::FEN_ON);
    assign par_lock  = s_reg.secure && (prom_mode == fcs_pkg::MODE_PAR);
    assign is555     = cmd_addr(fa, fcs_pkg::ADDR_LO_555);
    assign isaaa     = cmd_addr(fa, fcs_pkg::ADDR_LO_AAA);
    assign start_unl = is555 && (fd == fcs_pkg::D_UNLOCK1);

    // ------------------------------------------------------------
    // Sequencer, register file and read path
    // ------------------------------------------------------------
    always_comb
    begin
        s_next        = s_reg;
        s_next.pready = acc;
        // Cycles spent busy; only the program time check reads it
        s_next.busy_cnt = s_reg.busy ? s_reg.busy_cnt + fcs_pkg::TW'(1) : '0;
        tmr_start     = 1'b0;
        tmr_cycles    = '0;
        if (acc)
            s_next.pslverr = 1'b0;
        // Flash command writes; disabled or busy writes are dropped
        if (fw && en && !s_reg.busy)
        begin
            // F0 as program data is a byte to store, not an exit
            if (fd == fcs_pkg::D_ID_EXIT && s_reg.st != ST_PROG)
            begin
                s_next.id_mode = 1'b0;
                s_next.st      = ST_IDLE;
            end
            else
            begin
                // Mismatch falls back, but a fresh AA at 555 restarts at once
                s_next.st = start_unl ? ST_UNL1 : ST_IDLE;
                unique case (s_reg.st)
                    ST_IDLE:
                        s_next.st = start_unl ? ST_UNL1 : ST_IDLE;
                    ST_UNL1:
                        if (isaaa && fd == fcs_pkg::D_UNLOCK2)
                            s_next.st = ST_UNL2;
                    ST_UNL2:
                        if (is555 && fd == fcs_pkg::D_PROG)
                            s_next.st = ST_PROG;
                        else if (is555 && fd == fcs_pkg::D_ERASE)
                            s_next.st = ST_ER3;
                        else if (is555 && fd == fcs_pkg::D_ID_ENTRY)
                        begin
                            s_next.id_mode = 1'b1;
                            s_next.st      = ST_IDLE;
                        end
                        else if (is555 && fd == fcs_pkg::D_SECURE)
                            s_next.st = ST_SECP;
                    ST_PROG:
                        if (in_window(fa) && !par_lock)
                        begin
                            s_next.op  = OP_PROG;
                            s_next.st  = ST_HOLD;
                            tmr_start  = 1'b1;
                            tmr_cycles = fcs_pkg::TW'(fcs_pkg::PROG_CYCLES);
                        end
                    ST_ER3:
                        if (start_unl)
                            s_next.st = ST_ER4;
                    ST_ER4:
                        if (isaaa && fd == fcs_pkg::D_UNLOCK2)
                            s_next.st = ST_ER5;
                    ST_ER5:
                        if (is555 && fd == fcs_pkg::D_CHIP)
                        begin
                            s_next.op  = OP_CHIP;
                            s_next.st  = ST_HOLD;
                            tmr_start  = 1'b1;
                            tmr_cycles = fcs_pkg::TW'(ERASE_CYCLES);
                        end
                        else if (fd == fcs_pkg::D_SECTOR && in_window(fa)
                                 && prom_mode != fcs_pkg::MODE_PAR)
                        begin
                            s_next.op  = OP_SECT;
                            s_next.st  = ST_HOLD;
                            tmr_start  = 1'b1;
                            tmr_cycles = fcs_pkg::TW'(ERASE_CYCLES);
                        end
                    ST_SECP:
                        if (fa == fcs_pkg::A_SEC_STATUS && fd == fcs_pkg::D_SEC_DATA)
                        begin
                            s_next.op  = OP_SECP;
                            s_next.st  = ST_HOLD;
                            tmr_start  = 1'b1;
                            tmr_cycles = fcs_pkg::TW'(fcs_pkg::SECP_CYCLES);
                        end
                    ST_HOLD:
                        s_next.st = ST_IDLE;
                    default:
                        s_next.st = ST_IDLE;
                endcase
            end
            if (tmr_start)
            begin
                s_next.busy     = 1'b1;
                s_next.toggle   = 1'b1;
                s_next.tgt_addr = fa;
                s_next.tgt_data = fd;
            end
        end
        // Completion: protection changes land with the end of the operation
        if (tmr_done)
        begin
            s_next.busy = 1'b0;
            s_next.st   = ST_IDLE;
            if (s_reg.op == OP_CHIP)
                s_next.secure = 1'b0;
            if (s_reg.op == OP_SECP)
                s_next.secure = 1'b1;
        end
        // Flash reads
        if (fr)
        begin
            s_next.prdata = '0;
            if (s_reg.busy)
            begin
                s_next.prdata[7:0]                 = arr_rdata;
                s_next.prdata[fcs_pkg::TOGGLE_BIT] = s_reg.toggle;
                if (en)
                    s_next.toggle = !s_reg.toggle;
            end
            else if (s_reg.id_mode)
            begin
                if (fa == fcs_pkg::A_VENDOR_ID)
                    s_next.prdata[7:0] = VENDOR_ID;
                else if (fa == fcs_pkg::A_FLASH_ID)
                    s_next.prdata[7:0] = FLASH_ID;
                else if (fa == fcs_pkg::A_SEC_STATUS)
                    s_next.prdata[7:0] = s_reg.secure ? fcs_pkg::SEC_ON_BYTE
                                                      : fcs_pkg::ERASED_BYTE;
            end
            else if (!par_lock && in_window(fa))
                s_next.prdata[7:0] = arr_rdata;
        end
        // Register accesses; holding register and commit key
        if (acc && !paddr[fcs_pkg::WIN_BIT])
        begin
            s_next.prdata = '0;
            if (paddr == fcs_pkg::REG_CTRL_ONE)
            begin
                s_next.prdata[5:0] = {s_reg.area_pend, 1'b0, s_reg.fen_pend};
                if (pwrite)
                begin
                    s_next.fen_pend  = pwdata[2:0];
                    s_next.area_pend = pwdata[5:4];
                end
            end
            else if (paddr == fcs_pkg::REG_COMMIT)
            begin
                if (pwrite && fd == fcs_pkg::COMMIT_KEY)
                begin
                    s_next.fen_act  = s_reg.fen_pend;
                    s_next.area_act = s_reg.area_pend;
                end
            end
            else if (paddr == fcs_pkg::REG_STATUS)
                s_next.prdata[7:0] = {2'b00, s_reg.area_act, en,
                                      s_reg.secure, s_reg.id_mode, s_reg.busy};
            else
                s_next.pslverr = 1'b1;
        end
        // Serial loader refused while protected
        s_next.lock = s_next.secure && (prom_mode == fcs_pkg::MODE_SER);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_reg <= RESET_S;
        else
            s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // Array strobes and submodules
    // ------------------------------------------------------------
    assign arr_we    = tmr_done && s_reg.op == OP_PROG;
    assign arr_esect = tmr_done && s_reg.op == OP_SECT;
    assign arr_eall  = tmr_done && s_reg.op == OP_CHIP;

    fcs_timer #(.W(fcs_pkg::TW)) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (tmr_start),
        .cycles  (tmr_cycles),
        .done    (tmr_done)
    );

    fcs_array u_array (
        .pclk       (pclk),
        .presetn    (presetn),
        .we         (arr_we),
        .waddr      (s_reg.tgt_addr[fcs_pkg::ARRAY_AW-1:0]),
        .wdata      (s_reg.tgt_data),
        .erase_sect (arr_esect),
        .erase_all  (arr_eall),
        .sect       (s_reg.tgt_addr[fcs_pkg::ARRAY_AW-1 -: fcs_pkg::SECT_W]),
        .raddr      (fa[fcs_pkg::ARRAY_AW-1:0]),
        .rdata      (arr_rdata)
    );

    // Outputs straight from the state register
    assign prdata      = s_reg.prdata;
    assign pready      = s_reg.pready;
    assign pslverr     = s_reg.pslverr;
    assign flash_busy  = s_reg.busy;
    assign loader_lock = s_reg.lock;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int PROG_LIM = fcs_pkg::PROG_CYCLES + 2;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_id_entry;
        s_reg.st == ST_UNL2 && fw && en && !s_reg.busy && is555 && fd == fcs_pkg::D_ID_ENTRY
            |=> s_reg.id_mode;
    endproperty
    a_id_entry: assert property (p_id_entry) else $error("id entry missed");

    property p_id_exit;
        fw && en && !s_reg.busy && s_reg.st != ST_PROG && fd == fcs_pkg::D_ID_EXIT |=> !s_reg.id_mode;
    endproperty
    a_id_exit: assert property (p_id_exit) else $error("id exit missed");

    property p_prog_start;
        s_reg.st == ST_PROG && fw && en && !s_reg.busy && in_window(fa) && !par_lock
            |=> s_reg.busy && s_reg.toggle;
    endproperty
    a_prog_start: assert property (p_prog_start) else $error("program not started");

    property p_busy_ignore;
        s_reg.busy && fw && !tmr_done |=> s_reg.st == $past(s_reg.st) && s_reg.busy;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

    property p_toggle;
        s_reg.busy && fr && en && !tmr_done
            |=> s_reg.prdata[fcs_pkg::TOGGLE_BIT] == $past(s_reg.toggle) && s_reg.toggle != $past(s_reg.toggle);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle bit stuck");

    property p_sect_par;
        s_reg.st == ST_ER5 && fw && en && !s_reg.busy && prom_mode == fcs_pkg::MODE_PAR
            && fd == fcs_pkg::D_SECTOR |=> !s_reg.busy;
    endproperty
    a_sect_par: assert property (p_sect_par) else $error("sector erase in parallel mode");

    property p_chip_clear;
        tmr_done && s_reg.op == OP_CHIP |=> !s_reg.secure && !s_reg.busy;
    endproperty
    a_chip_clear: assert property (p_chip_clear) else $error("chip erase kept protection");

    property p_prog_time;
        s_reg.busy && s_reg.op == OP_PROG |-> s_reg.busy_cnt <= fcs_pkg::TW'(PROG_LIM);
    endproperty
    a_prog_time: assert property (p_prog_time) else $error("program too slow");

    property p_disabled;
        fw && !en && !tmr_done |=> s_reg.st == $past(s_reg.st) && !$rose(s_reg.busy);
    endproperty
    a_disabled: assert property (p_disabled) else $error("command while disabled");
endmodule
`default_nettype wire

// [fcs_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module fcs_timer #(
    parameter int W = fcs_pkg::TW
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         start,
    input  wire logic [W-1:0] cycles,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] count;
        logic         done;
    } fcs_tmr_t;

    fcs_tmr_t s_reg;
    fcs_tmr_t s_next;

    // Count down; done pulses for one cycle, set at the same edge as the count reaches zero
    always_comb
    begin
        s_next      = s_reg;
        s_next.done = (s_reg.count == W'(1));
        if (start)
            s_next.count = cycles;
        else if (s_reg.count != '0)
            s_next.count = s_reg.count - W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign done = s_reg.done;
endmodule
`default_nettype wire

// [test_flash_command_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
module test_flash_command_sequencer;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [1:0]  prom_mode = 2'h0;
    logic        psel, penable, pwrite, pready, pslverr, flash_busy, loader_lock, err;
    logic [16:0] paddr;
    logic [31:0] pwdata, prdata, q, q2;
    int          error_cnt = 0;
    int          comparisons = 0;
    // Clock never stops: the host stays out of low-power modes throughout
    always #12.5 pclk = ~pclk;
    // Short erase so the run stays small
    fcs_sequencer #(.ERASE_CYCLES(50)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prom_mode(prom_mode), .flash_busy(flash_busy), .loader_lock(loader_lock));
    fcs_cpu_model u_cpu (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .err(err));
    task automatic results();
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tmo();
        $display("[ERR] pready expected 1 seen 0");
        error_cnt++;
        results();
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic fw(input logic [15:0] a, input logic [7:0] d);
        u_cpu.xfer(1'b1, {1'b1, a}, d, q);
    endtask
    task automatic fr(input logic [15:0] a, input logic [7:0] e, input string nm);
        u_cpu.xfer(1'b0, {1'b1, a}, 8'h00, q);
        chk(nm, {24'h000000, e}, q);
    endtask
    task automatic unl(input logic [3:0] h);
        fw({h, 12'h555}, 8'hAA);
        fw({h, 12'hAAA}, 8'h55);
    endtask
    // Paired reads until they agree; lim bounds the reads after the first
    task automatic poll(input logic [15:0] a, input int lim);
        int n;
        u_cpu.xfer(1'b0, {1'b1, a}, 8'h00, q);
        chk("first toggle", 32'h1, q[6]);
        n = 0;
        do
        begin
            q2 = q;
            u_cpu.xfer(1'b0, {1'b1, a}, 8'h00, q);
            if (n == 0)
                chk("toggle flips", {31'h0, ~q2[6]}, q[6]);
            n++;
        end
        while (q !== q2 && n < lim);
        chk("done in time", 32'h0, flash_busy);
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        unl(4'hF);
        fw(16'hF555, 8'hA0);
        fw(16'hC010, 8'h00);
        chk("disabled busy", 32'h0, flash_busy);
        fr(16'hC010, 8'hFF, "disabled");
        u_cpu.xfer(1'b0, 17'h0000C, 8'h00, q);
        chk("unmapped", 32'h1, err);
        u_cpu.xfer(1'b1, fcs_pkg::REG_CTRL_ONE, 8'h05, q);
        u_cpu.xfer(1'b1, fcs_pkg::REG_COMMIT, fcs_pkg::COMMIT_KEY, q);
        u_cpu.xfer(1'b0, fcs_pkg::REG_STATUS, 8'h00, q);
        chk("enabled", 32'h1, q[3]);
        unl(4'hC);
        fw(16'hC555, 8'hA0);
        fw(16'hC123, 8'h3C);
        unl(4'hF);
        fw(16'hF555, 8'hA0);
        fw(16'hC124, 8'h00);
        poll(16'hC123, fcs_pkg::PROG_CYCLES / 3 + 2);
        fr(16'hC123, 8'h3C, "program");
        fr(16'hC124, 8'hFF, "busy ignore");
        unl(4'hE);
        fw(16'hE555, 8'hA0);
        fw(16'hD000, 8'h5A);
        poll(16'hD000, fcs_pkg::PROG_CYCLES / 3 + 2);
        unl(4'hF);
        fw(16'hF555, 8'hA0);
        fw(16'hE000, 8'hF0);
        poll(16'hE000, fcs_pkg::PROG_CYCLES / 3 + 2);
        fr(16'hE000, 8'hF0, "program F0");
        unl(4'hF);
        fw(16'hF555, 8'h80);
        unl(4'hF);
        fw(16'hCFFF, 8'h30);
        poll(16'hC000, 20);
        fr(16'hC123, 8'hFF, "sector");
        fr(16'hD000, 8'h5A, "other sector");
        prom_mode <= fcs_pkg::MODE_PAR;
        unl(4'hF);
        fw(16'hF555, 8'h80);
        unl(4'hF);
        fw(16'hD000, 8'h30);
        chk("parallel busy", 32'h0, flash_busy);
        prom_mode <= fcs_pkg::MODE_MCU;
        unl(4'hF);
        fw(16'hF555, 8'h90);
        fr(16'hF000, 8'h11, "vendor");
        fr(16'hF001, 8'h22, "flash id");
        fr(16'hFF7F, 8'hFF, "sec off");
        unl(4'hF);
        fw(16'hF555, 8'hA5);
        fw(16'hFF7F, 8'h00);
        poll(16'hC000, fcs_pkg::SECP_CYCLES / 3 + 2);
        fr(16'hFF7F, 8'h00, "sec on");
        prom_mode <= fcs_pkg::MODE_SER;
        @(posedge pclk);
        @(posedge pclk);
        chk("loader lock", 32'h1, loader_lock);
        prom_mode <= fcs_pkg::MODE_MCU;
        fw(16'h1234, 8'hF0);
        fr(16'hF000, 8'hFF, "id exit");
        unl(4'hF);
        fw(16'hF555, 8'h80);
        unl(4'hF);
        fw(16'hF555, 8'h10);
        poll(16'hC000, 20);
        fr(16'hD000, 8'hFF, "chip");
        unl(4'hF);
        fw(16'hF555, 8'h90);
        fr(16'hFF7F, 8'hFF, "sec cleared");
        results();
    end
endmodule
`default_nettype wire
